// [rtl/itt_pkg.sv]
/*
 Package for the interval and time-base timer: register offsets, field
 positions, reset values and prescaler tap positions.
 Assumes a 40 MHz system clock and a 32.768 kHz sub-clock arriving on a pin.
*/
package itt_pkg;
   // ----------------------------------------
   // Register map (AXI4-Lite byte addresses)
   // ----------------------------------------
   localparam logic [3:0] ITT_OFF_MODE = 4'h0;
   localparam logic [3:0] ITT_OFF_COUNT = 4'h4;
   localparam logic [3:0] ITT_OFF_IRQ_STATUS = 4'h8;
   localparam logic [3:0] ITT_OFF_IRQ_MASK = 4'hC;
   // ----------------------------------------
   // Fields and reset values
   // ----------------------------------------
   localparam int ITT_MODE_RSVD_BIT = 4;
   localparam logic [7:0] ITT_MODE_RESET = 8'h10;
   localparam logic [7:0] ITT_COUNT_RESET = 8'h00;
   localparam logic [7:0] ITT_SUB_PRE_RESET = 8'h00;
   localparam logic [12:0] ITT_SYS_PRE_RESET = 13'h0000;
   localparam int ITT_IRQ_OVF_BIT = 0;
   // ----------------------------------------
   // Sub-clock and time-base figures
   // ----------------------------------------
   localparam int ITT_SUBCLK_HZ = 32768;
   localparam int ITT_SUB_TAP_DIV = 128;
   localparam int ITT_SYNC_STAGES = 3;
   // Chip operating modes
   typedef enum logic [2:0] {
      ITT_PM_ACTIVE = 3'h0,
      ITT_PM_SLEEP = 3'h1,
      ITT_PM_WATCH = 3'h3,
      ITT_PM_SUBACTIVE = 3'h2,
      ITT_PM_SUBSLEEP = 3'h6,
      ITT_PM_STANDBY = 3'h7
   } itt_pmode_t;
endpackage : itt_pkg

// [rtl/itt_timer.sv]
/*
 Interval and time-base timer: 8-bit up-counter clocked either from a
 system-clock prescaler or from a sub-clock prescaler, overflow interrupt,
 divided-clock output pin, AXI4-Lite register slave.
 Assumes the sub-clock is a 32.768 kHz level arriving from outside aclk's
 domain, and that the chip power mode is supplied on a port.
*/
`timescale 1ns/1ps
`default_nettype none
module itt_timer (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic subclk,
   input wire logic [2:0] power_mode,
   input wire logic port_mode_reg_one,
   output logic divided_clock_out_pin,
   output logic irq,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import itt_pkg::*;

   logic [7:0] timer_mode_select_q;
   logic [7:0] timer_count_value_q;
   logic [12:0] sys_pre_q;
   logic [7:0] sub_pre_q;
   logic [2:0] sub_sync_q;
   logic sub_rise;
   logic overflow_request_flag_q;
   logic overflow_irq_enable_q;
   logic [2:0] output_clock_select;
   logic [3:0] count_source_select;
   logic sys_tick;
   logic sub_tap_tick;
   logic tb_tick;
   logic cnt_tick;
   logic cnt_run;
   logic is_active;
   logic is_sleep;
   logic is_sub;
   logic is_standby;
   logic mode_wr_ok;
   logic ovf_evt;
   logic clr_hold;
   logic wout_d;
   logic wout_q;
   logic aw_hold_q;
   logic w_hold_q;
   logic [3:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic wr_go;
   logic [31:0] rd_word;
   logic rd_hit;

   assign output_clock_select = timer_mode_select_q[7:5];
   assign count_source_select = timer_mode_select_q[3:0];

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Carry tick into prescaler bit b: all lower bits ones, so bit b is about to toggle
   function automatic logic carry_at(input logic [12:0] v, input int b);
      logic r;
      r = 1'b1;
      for (int i = 0; i < 13; i++) begin
         if (i < b && !v[i]) begin
            r = 1'b0;
         end
      end
      return r;
   endfunction : carry_at

   // ------------------------------------------------------------
   // Power mode decode
   // ------------------------------------------------------------
   assign is_active = (power_mode == ITT_PM_ACTIVE);
   assign is_sleep = (power_mode == ITT_PM_SLEEP);
   assign is_sub = (power_mode == ITT_PM_SUBACTIVE);
   assign is_standby = (power_mode == ITT_PM_STANDBY);
   assign mode_wr_ok = is_active | is_sub;
   assign clr_hold = count_source_select[3] & count_source_select[2];

   // ------------------------------------------------------------
   // Sub-clock synchroniser
   // ------------------------------------------------------------
   // Three stages; the edge is judged on stages two and three only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sub_sync_q <= 3'h0;
      end else if (clk_en) begin
         sub_sync_q <= {sub_sync_q[1:0], subclk};
      end
   end
   assign sub_rise = sub_sync_q[1] & ~sub_sync_q[2];

   // ------------------------------------------------------------
   // Prescalers
   // ------------------------------------------------------------
   // System prescaler runs free; halted only in standby to save power
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sys_pre_q <= ITT_SYS_PRE_RESET;
      end else if (clk_en && !is_standby) begin
         sys_pre_q <= sys_pre_q + 13'h0001;
      end
   end

   // Sub-clock prescaler counts synchronised sub-clock edges
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sub_pre_q <= ITT_SUB_PRE_RESET;
      end else if (clk_en) begin
         if (clr_hold) begin
            sub_pre_q <= ITT_SUB_PRE_RESET;
         end else if (sub_rise) begin
            sub_pre_q <= sub_pre_q + 8'h01;
         end
      end
   end

   // Sub-clock /128 tap: 256 Hz, so 256 ticks to overflow gives 1 s
   assign sub_tap_tick = sub_rise & (sub_pre_q[6:0] == 7'h7F);

   // ------------------------------------------------------------
   // Count source selection
   // ------------------------------------------------------------
   always_comb begin
      sys_tick = 1'b0;
      case (count_source_select[2:0])
         3'h0: sys_tick = carry_at(sys_pre_q, 13);
         3'h1: sys_tick = carry_at(sys_pre_q, 12);
         3'h2: sys_tick = carry_at(sys_pre_q, 11);
         3'h3: sys_tick = carry_at(sys_pre_q, 9);
         3'h4: sys_tick = carry_at(sys_pre_q, 8);
         3'h5: sys_tick = carry_at(sys_pre_q, 7);
         3'h6: sys_tick = carry_at(sys_pre_q, 5);
         default: sys_tick = carry_at(sys_pre_q, 3);
      endcase
   end

   // Time-base ratios shorten the period by pre-advancing the count
   always_comb begin
      tb_tick = sub_tap_tick;
   end

   always_comb begin
      if (count_source_select[3]) begin
         cnt_run = !is_standby;
         cnt_tick = tb_tick & cnt_run;
      end else begin
         cnt_run = is_active | is_sleep;
         cnt_tick = sys_tick & cnt_run;
      end
   end

   // ------------------------------------------------------------
   // Counter
   // ------------------------------------------------------------
   // Time-base periods 0.5/0.25/0.03125 s skip part of the count range
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer_count_value_q <= ITT_COUNT_RESET;
      end else if (clk_en) begin
         if (clr_hold) begin
            timer_count_value_q <= ITT_COUNT_RESET;
         end else if (cnt_tick) begin
            if (count_source_select[3] && timer_count_value_q == 8'hFF) begin
               case (count_source_select[1:0])
                  2'h0: timer_count_value_q <= 8'h00;
                  2'h1: timer_count_value_q <= 8'h80;
                  2'h2: timer_count_value_q <= 8'hC0;
                  default: timer_count_value_q <= 8'hF8;
               endcase
            end else begin
               timer_count_value_q <= timer_count_value_q + 8'h01;
            end
         end
      end
   end
   assign ovf_evt = cnt_tick & ~clr_hold & (timer_count_value_q == 8'hFF);

   // ------------------------------------------------------------
   // Waveform output
   // ------------------------------------------------------------
   always_comb begin
      wout_d = 1'b0;
      case (output_clock_select)
         3'h0: wout_d = sys_pre_q[4] & (is_active | is_sleep);
         3'h1: wout_d = sys_pre_q[3] & (is_active | is_sleep);
         3'h2: wout_d = sys_pre_q[2] & (is_active | is_sleep);
         3'h3: wout_d = sys_pre_q[1] & (is_active | is_sleep);
         3'h4: wout_d = sub_pre_q[4] & (is_active | is_sleep | is_sub);
         3'h5: wout_d = sub_pre_q[3] & (is_active | is_sleep | is_sub);
         3'h6: wout_d = sub_pre_q[2] & (is_active | is_sleep | is_sub);
         default: wout_d = sub_pre_q[1] & (is_active | is_sleep | is_sub);
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wout_q <= 1'b0;
      end else if (clk_en) begin
         wout_q <= wout_d & port_mode_reg_one;
      end
   end
   assign divided_clock_out_pin = wout_q;

   // ------------------------------------------------------------
   // AXI4-Lite write path
   // ------------------------------------------------------------
   assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
   assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
   assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;

   // Address and data are captured independently, in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         aw_addr_q <= 4'h0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
      end else if (clk_en) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   assign s_axi_bresp = 2'b00;

   // Mode register; reserved bit is forced, writes outside active/subactive dropped
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer_mode_select_q <= ITT_MODE_RESET;
      end else if (clk_en && wr_go && w_strb_q[0] && aw_addr_q == ITT_OFF_MODE && mode_wr_ok) begin
         timer_mode_select_q <= {w_data_q[7:5], 1'b1, w_data_q[3:0]};
      end
   end

   // Interrupt enable (mask) register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         overflow_irq_enable_q <= 1'b0;
      end else if (clk_en && wr_go && w_strb_q[0] && aw_addr_q == ITT_OFF_IRQ_MASK) begin
         overflow_irq_enable_q <= w_data_q[ITT_IRQ_OVF_BIT];
      end
   end

   // Sticky flag; a same-cycle overflow beats the write-one clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         overflow_request_flag_q <= 1'b0;
      end else if (clk_en) begin
         if (ovf_evt) begin
            overflow_request_flag_q <= 1'b1;
         end else if (wr_go && w_strb_q[0] && aw_addr_q == ITT_OFF_IRQ_STATUS && w_data_q[ITT_IRQ_OVF_BIT]) begin
            overflow_request_flag_q <= 1'b0;
         end
      end
   end
   assign irq = overflow_request_flag_q & overflow_irq_enable_q;

   // ------------------------------------------------------------
   // AXI4-Lite read path
   // ------------------------------------------------------------
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit = 1'b1;
      case (s_axi_araddr)
         ITT_OFF_MODE: rd_word = {24'h000000, timer_mode_select_q};
         ITT_OFF_COUNT: rd_word = {24'h000000, timer_count_value_q};
         ITT_OFF_IRQ_STATUS: rd_word = {31'h0000_0000, overflow_request_flag_q};
         ITT_OFF_IRQ_MASK: rd_word = {31'h0000_0000, overflow_irq_enable_q};
         default: rd_hit = 1'b0;
      endcase
   end

   assign s_axi_arready = !s_axi_rvalid;

   // One-cycle read answer; unmapped addresses give SLVERR
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else if (clk_en) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : itt_timer
`default_nettype wire

// [verification/itt_subosc.sv]
/* Sub-clock oscillator model for the timer bench.
   Assumes the bench picks a fast half period to keep time-base runs short. */
`timescale 1ns/1ps
`default_nettype none
module itt_subosc #(parameter int HALF_NS = 50) (
   input wire logic run,
   output logic subclk
);
   // Crystal runs free; held low only when stopped
   initial begin
      subclk = 1'b0;
      forever begin
         #(HALF_NS);
         subclk = run ? ~subclk : 1'b0;
      end
   end
endmodule : itt_subosc
`default_nettype wire

// [verification/itt_timer_checker.sv]
/* Concurrent checks on the timer's ports.
   Assumes one clock domain and the register map of the package. */
`timescale 1ns/1ps
`default_nettype none
module itt_timer_checker
   import itt_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic [2:0] power_mode,
   input wire logic port_mode_reg_one,
   input wire logic divided_clock_out_pin,
   input wire logic irq,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [3:0] rd_addr_q;
   // Address of the read in flight, so read data can be judged
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_addr_q <= 4'h0;
      end else if (s_axi_arvalid && s_axi_arready && clk_en) begin
         rd_addr_q <= s_axi_araddr;
      end
   end
   rst_quiet_a: assert property ($rose(aresetn) |-> !irq && !s_axi_bvalid && !s_axi_rvalid)
      else $error("outputs busy right after reset");
   pin_gate_a: assert property (!port_mode_reg_one [*2] |-> !divided_clock_out_pin)
      else $error("clock pin active while disabled");
   watch_pin_a: assert property ((power_mode == ITT_PM_WATCH) [*2] |-> !divided_clock_out_pin)
      else $error("clock pin active in watch mode");
   bresp_ok_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00)
      else $error("write response not okay");
   wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clk_en
      |-> ##2 s_axi_bvalid)
      else $error("write response late");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid)
      else $error("read response late");
   b_once_a: assert property (s_axi_bvalid && s_axi_bready && clk_en |=> !s_axi_bvalid)
      else $error("write response repeated");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
   rd_ok_a: assert property (s_axi_rvalid && rd_addr_q[1:0] == 2'b00 |-> s_axi_rresp == 2'b00)
      else $error("mapped read refused");
   rd_err_a: assert property (s_axi_rvalid && rd_addr_q[1:0] != 2'b00 |-> s_axi_rresp == 2'b10)
      else $error("unmapped read not refused");
   rsvd_read_a: assert property (s_axi_rvalid && rd_addr_q == ITT_OFF_MODE |-> s_axi_rdata[ITT_MODE_RSVD_BIT])
      else $error("reserved mode bit read as zero");
endmodule : itt_timer_checker
bind itt_timer itt_timer_checker chk_u (.aclk, .aresetn, .clk_en, .power_mode, .port_mode_reg_one,
   .divided_clock_out_pin, .irq, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid);
`default_nettype wire

// [verification/tb_itt_timer.sv]
/* Self-checking bench for the timer over AXI4-Lite.
   Assumes the checker is bound and the sub-clock model runs at 10 MHz. */
`timescale 1ns/1ps
`default_nettype none
module tb_itt_timer;
   import itt_pkg::*;
   logic aclk, aresetn, clk_en, subclk, port_mode_reg_one, divided_clock_out_pin, irq;
   logic [2:0] power_mode;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int n_errors = 0;
   int total_checks = 0;
   int cyc = 0;
   itt_subosc #(.HALF_NS(50)) osc_u (.run(1'b1), .subclk(subclk));
   itt_timer dut_u (.aclk, .aresetn, .clk_en, .subclk, .power_mode, .port_mode_reg_one,
      .divided_clock_out_pin, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   // ----------------------------------------
   // Clock, hang guard, verdict
   // ----------------------------------------
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   // Whole run needs about 48k cycles
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_errors++;
         close_out();
      end
   end
   task automatic close_out();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : close_out
   // ----------------------------------------
   // Bus and compare tasks
   // ----------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Address and data offered together; each dropped when taken
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata[7:0];
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask : rd
   task automatic rc(input logic [3:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      chk({8'h0, d}, {8'h0, e});
   endtask : rc
   // Rising edges on the clock pin over a window
   task automatic edges(input int w, output int n);
      logic p;
      p = divided_clock_out_pin;
      n = 0;
      repeat (w) begin
         @(posedge aclk);
         if (divided_clock_out_pin && !p) n++;
         p = divided_clock_out_pin;
      end
   endtask : edges
   task automatic wait_irq(output int t);
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 10000) begin
         @(posedge aclk);
         n++;
      end
      t = cyc;
   endtask : wait_irq
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      int n, e, t0, t1;
      int ratio_tab [8];
      logic [7:0] v;
      logic [7:0] w;
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      clk_en = 1'b1;
      power_mode = ITT_PM_ACTIVE;
      port_mode_reg_one = 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rc(ITT_OFF_MODE, ITT_MODE_RESET);
      rc(ITT_OFF_COUNT, ITT_COUNT_RESET);
      rc(ITT_OFF_IRQ_STATUS, 8'h00);
      rc(4'h2, 8'h00);
      wr(ITT_OFF_MODE, 8'hE7);
      rc(ITT_OFF_MODE, 8'hF7);
      wr(ITT_OFF_COUNT, 8'hC3);
      rd(ITT_OFF_COUNT, v);
      chk(16'(v < 8'h40), 16'h1);
      edges(256, n);
      chk(16'(n), 16'h0);
      port_mode_reg_one <= 1'b1;
      // All eight pin selections: system /32../4, then sub-clock /32../4
      for (int s = 0; s < 8; s++) begin
         wr(ITT_OFF_MODE, {s[2:0], 5'h10});
         edges(s < 4 ? 256 : 1024, n);
         e = 8 << s[1:0];
         chk(16'(n >= e - 1 && n <= e + 1), 16'h1);
      end
      power_mode <= ITT_PM_SUBACTIVE;
      wr(ITT_OFF_MODE, 8'h70);
      edges(256, n);
      chk(16'(n), 16'h0);
      wr(ITT_OFF_MODE, 8'hF0);
      edges(256, n);
      chk(16'(n >= 15 && n <= 17), 16'h1);
      // Interval mode at /8: overflow, mask, sticky flag, period
      power_mode <= ITT_PM_ACTIVE;
      wr(ITT_OFF_MODE, 8'h0C);
      wr(ITT_OFF_IRQ_MASK, 8'h01);
      wr(ITT_OFF_MODE, 8'h07);
      wait_irq(t0);
      rc(ITT_OFF_IRQ_STATUS, 8'h01);
      rd(ITT_OFF_COUNT, v);
      chk(16'(v < 8'h10), 16'h1);
      wr(ITT_OFF_IRQ_MASK, 8'h00);
      chk({15'h0, irq}, 16'h0);
      rc(ITT_OFF_IRQ_STATUS, 8'h01);
      wr(ITT_OFF_IRQ_MASK, 8'h01);
      wr(ITT_OFF_IRQ_STATUS, 8'h01);
      chk({15'h0, irq}, 16'h0);
      wait_irq(t1);
      chk(16'(t1 - t0), 16'd2048);
      // Near the top of the count, hand over to the 0.03125 s time base
      repeat (1950) @(posedge aclk);
      power_mode <= ITT_PM_SUBACTIVE;
      wr(ITT_OFF_MODE, 8'h0B);
      wr(ITT_OFF_IRQ_STATUS, 8'h01);
      wait_irq(t0);
      wr(ITT_OFF_IRQ_STATUS, 8'h01);
      wait_irq(t1);
      chk(16'(t1 - t0 >= 4095 && t1 - t0 <= 4097), 16'h1);
      power_mode <= ITT_PM_ACTIVE;
      rd(ITT_OFF_COUNT, v);
      chk(16'(v >= 8'hF8), 16'h1);
      wr(ITT_OFF_MODE, 8'h0C);
      repeat (300) @(posedge aclk);
      rc(ITT_OFF_COUNT, 8'h00);
      // Interval ratios /4096 to /32: pulses counted from zero over a fixed window
      ratio_tab = '{8192, 4096, 2048, 512, 256, 128, 32, 8};
      for (int s = 1; s < 7; s++) begin
         wr(ITT_OFF_MODE, 8'h0C);
         wr(ITT_OFF_MODE, {5'h00, s[2:0]});
         repeat (4096) @(posedge aclk);
         rd(ITT_OFF_COUNT, v);
         e = 4096 / ratio_tab[s];
         chk(16'(int'(v) >= e - 1 && int'(v) <= e + 1), 16'h1);
      end
      // Interval halts in watch; mode writes ignored in sleep
      wr(ITT_OFF_MODE, 8'h07);
      power_mode <= ITT_PM_WATCH;
      rd(ITT_OFF_COUNT, v);
      repeat (200) @(posedge aclk);
      rc(ITT_OFF_COUNT, v);
      power_mode <= ITT_PM_SLEEP;
      wr(ITT_OFF_MODE, 8'h0B);
      rc(ITT_OFF_MODE, 8'h17);
      // Clock enable low must freeze the count although sleep keeps it running
      rd(ITT_OFF_COUNT, v);
      clk_en <= 1'b0;
      repeat (400) @(posedge aclk);
      clk_en <= 1'b1;
      rd(ITT_OFF_COUNT, w);
      chk(16'(8'(w - v) <= 8'h01), 16'h1);
      close_out();
   end
endmodule : tb_itt_timer
`default_nettype wire
